// File: core/t8pwm_wave_unit.sv
// Counter, compare and waveform logic of the 8-bit timer with a Wishbone slave.
module t8pwm_wave_unit (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    output t8pwm_pkg::t8pwm_pin_t pinA,
    output t8pwm_pkg::t8pwm_pin_t pinB,
    output logic ovfIrq
);
    import t8pwm_pkg::*;

    logic [7:0] ctrlA_ff, ctrlB_ff, cmpBufA_ff, cmpBufB_ff, cmpA_ff, cmpB_ff, count_ff;
    logic [7:0] nxt_count;
    logic [1:0] pinCtl_ff;
    logic [2:0] status_ff;
    logic [9:0] presc_ff;
    logic down_ff, waveA_ff, waveB_ff, ackFlag_ff;
    logic [31:0] rdData_ff;
    t8pwm_pin_t pinA_ff, pinB_ff;
    logic irq_ff;

    // Mode decode from both control registers.
    wire logic [1:0] modeA = ctrlA_ff[MODE_A_POS +: 2];
    wire logic [1:0] modeB = ctrlA_ff[MODE_B_POS +: 2];
    wire t8pwm_wmode_t wmode = t8pwm_wmode_t'({ctrlB_ff[WAVE_MSB_POS], ctrlA_ff[1:0]});
    wire logic wmMsb = ctrlB_ff[WAVE_MSB_POS];
    wire logic isFast = (wmode == WM_FAST_FF) || (wmode == WM_FAST_OCA);
    wire logic isPc = (wmode == WM_PC_FF) || (wmode == WM_PC_OCA);
    wire logic isRsv = (wmode == WM_RSV4) || (wmode == WM_RSV6);
    wire logic [7:0] topVal = (wmode == WM_FAST_OCA || wmode == WM_PC_OCA
                               || wmode == WM_CTC) ? cmpA_ff : CNT_MAX;

    wire logic [2:0] clkSel = ctrlB_ff[PRESC_POS +: 3];
    wire logic [9:0] prescMask = (clkSel == 3'h2) ? PRESC_8 :
                                 (clkSel == 3'h3) ? PRESC_64 :
                                 (clkSel == 3'h4) ? PRESC_256 :
                                 (clkSel == 3'h5) ? PRESC_1024 : 10'h000;
    wire logic tick = (clkSel != 3'h0) && !isRsv && ((presc_ff & prescMask) == prescMask);

    wire logic atTop = (count_ff == topVal);
    wire logic atBottom = (count_ff == CNT_BOTTOM);
    wire logic matchA = (count_ff == cmpA_ff);
    wire logic matchB = (count_ff == cmpB_ff);

    always_comb begin
        nxt_count = count_ff + 8'h01;
        if (isPc) begin
            if (down_ff && !atBottom) nxt_count = count_ff - 8'h01;
            else if (atTop && !down_ff) nxt_count = count_ff - 8'h01;
        end else if ((isFast || wmode == WM_CTC) && atTop) begin
            nxt_count = CNT_BOTTOM;
        end
    end

    // Period edges: fast wraps at TOP, phase correct reverses at TOP and BOTTOM.
    wire logic wrapFast = isFast && atTop;
    wire logic turnTop = isPc && atTop && !down_ff;

    // Action on a channel, returns new level. Code 01 toggles; 1x sets to code bit 0, inverted when inv is set.
    function automatic logic chanAct(input logic cur, input logic [1:0] code, input logic inv);
        if (code == COM_TOG) return !cur;
        return code[0] ^ inv;
    endfunction

    // Legal-action decode for each channel; reserved codes leave the register alone.
    // toggle needs msb on A; never legal on B in PWM modes
    wire logic togOkA = !(isFast || isPc) || wmMsb;
    wire logic togOkB = !(isFast || isPc);
    wire logic actA = (modeA != COM_OFF) && (modeA != COM_TOG || togOkA);
    wire logic actB = (modeB != COM_OFF) && (modeB != COM_TOG || togOkB);

    // Next waveform level per channel (same structure, generic over A/B).
    function automatic logic nextWave(input logic cur, input logic [1:0] code, input logic act,
                                      input logic match, input logic [7:0] cmp);
        logic res;
        res = cur;
        if (act) begin
            if (isFast) begin
                if (code[1] && cmp == topVal) begin
                    // Non-inverting holds high, inverting holds low: the bottom action wins.
                    if (wrapFast) res = !code[0];
                end else if (code == COM_TOG) begin
                    if (match) res = !cur;
                end else if (match) begin
                    res = chanAct(cur, code, 1'b0);
                end else if (wrapFast) begin
                    res = !code[0];
                end
            end else if (isPc) begin
                if (code[1] && cmp == topVal) begin
                    if (turnTop) res = !code[0];
                end else if (code == COM_TOG) begin
                    if (match) res = !cur;
                end else if (match) begin
                    // A match at BOTTOM takes the up-count result, so compare zero stays flat.
                    res = chanAct(cur, code, down_ff && cmp != CNT_BOTTOM);
                end else if (turnTop && cmp > count_ff) begin
                    res = code[0];
                end
            end else if (match) begin
                res = chanAct(cur, code, 1'b0);
            end
        end
        return res;
    endfunction

    wire logic nxtWaveA = nextWave(waveA_ff, modeA, actA, matchA, cmpA_ff);
    wire logic nxtWaveB = nextWave(waveB_ff, modeB, actB, matchB, cmpB_ff);

    wire logic loadCmp = !(isFast || isPc) || (tick && (isFast ? wrapFast : turnTop));
    // bottom overflow in PC, TOP overflow in fast
    wire logic ovfEvt = tick && (isPc ? (down_ff && count_ff == 8'h01) :
                                 isFast ? atTop : (count_ff == CNT_MAX));

    // Bus decode; registers take byte lane 0 only.
    wire logic busReq = wb_cyc_i && wb_stb_i && !ackFlag_ff;
    wire logic wrLane = busReq && wb_we_i && wb_sel_i[0];
    wire logic [7:0] wadr = wb_adr_i[7:0];
    wire logic [7:0] wdat = wb_dat_i[7:0];
    wire logic [7:0] rdByte = (wadr == ADDR_CTRL_A) ? (ctrlA_ff & CTRL_A_MASK) :
                              (wadr == ADDR_CTRL_B) ? {4'h0, ctrlB_ff[3:0]} :
                              (wadr == ADDR_CMP_A) ? cmpBufA_ff :
                              (wadr == ADDR_CMP_B) ? cmpBufB_ff :
                              (wadr == ADDR_COUNT) ? count_ff :
                              (wadr == ADDR_STATUS) ? {5'h00, status_ff} :
                              (wadr == ADDR_PINCTL) ? {6'h00, pinCtl_ff} : 8'h00;
    wire logic clrStat = wrLane && wadr == ADDR_STATUS;

    // Bus slave: one wait state, ack for one cycle.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ackFlag_ff <= 1'b0;
            rdData_ff <= 32'h0000_0000;
        end else begin
            ackFlag_ff <= busReq;
            rdData_ff <= {24'h000000, rdByte};
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ctrlA_ff <= RESET_BYTE;
            ctrlB_ff <= RESET_BYTE;
            cmpBufA_ff <= RESET_BYTE;
            cmpBufB_ff <= RESET_BYTE;
            pinCtl_ff <= 2'h0;
        end else if (wrLane) begin
            if (wadr == ADDR_CTRL_A) ctrlA_ff <= wdat & CTRL_A_MASK;
            if (wadr == ADDR_CTRL_B) ctrlB_ff <= {4'h0, wdat[3:0]};
            if (wadr == ADDR_CMP_A) cmpBufA_ff <= wdat;
            if (wadr == ADDR_CMP_B) cmpBufB_ff <= wdat;
            if (wadr == ADDR_PINCTL) pinCtl_ff <= wdat[1:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cmpA_ff <= RESET_BYTE;
            cmpB_ff <= RESET_BYTE;
        end else if (loadCmp) begin
            cmpA_ff <= cmpBufA_ff;
            cmpB_ff <= cmpBufB_ff;
        end
    end

    // Prescaler free-runs; counter moves on ticks and bus writes, direction only on ticks and is held clear outside phase correct.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            presc_ff <= 10'h000;
            count_ff <= CNT_BOTTOM;
            down_ff <= 1'b0;
        end else begin
            presc_ff <= presc_ff + 10'h001;
            if (wrLane && wadr == ADDR_COUNT) count_ff <= wdat;
            else if (tick) count_ff <= nxt_count;
            if (!isPc || (tick && down_ff && atBottom)) down_ff <= 1'b0;
            else if (tick && atTop) down_ff <= 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            waveA_ff <= 1'b0;
            waveB_ff <= 1'b0;
        end else if (tick) begin
            waveA_ff <= nxtWaveA;
            waveB_ff <= nxtWaveB;
        end
    end

    // Sticky flags: bit0 overflow, bit1 match A, bit2 match B; write one clears, set wins.
    wire logic [2:0] setStat = {tick && matchB, tick && matchA, ovfEvt};
    wire logic [2:0] nxt_status = (status_ff & ~(clrStat ? wdat[2:0] : 3'h0)) | setStat;
    always_ff @(posedge core_clk) begin
        if (sys_rst) status_ff <= 3'h0;
        else status_ff <= nxt_status;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pinA_ff <= '0;
            pinB_ff <= '0;
            irq_ff <= 1'b0;
        end else begin
            pinA_ff <= '{level: nxtWaveA & tick | waveA_ff & !tick,
                         enable: actA && pinCtl_ff[0]};
            pinB_ff <= '{level: nxtWaveB & tick | waveB_ff & !tick,
                         enable: actB && pinCtl_ff[1]};
            irq_ff <= nxt_status[0];
        end
    end

    assign wb_ack_o = ackFlag_ff;
    assign wb_dat_o = rdData_ff;
    assign pinA = pinA_ff;
    assign pinB = pinB_ff;
    assign ovfIrq = irq_ff;

    // Overflow in phase correct only when leaving 1 downward.
    pc_ovf_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (isPc && tick && down_ff && count_ff == 8'h01) |=> status_ff[0])
        else $error("overflow flag missed at bottom");
    top_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (isPc && tick && atTop && !down_ff) |=> down_ff)
        else $error("direction did not reverse at top");
    fast_wrap_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (isFast && tick && atTop && !(wrLane && wadr == ADDR_COUNT)) |=> count_ff == CNT_BOTTOM)
        else $error("fast counter did not wrap");
    fast_ovf_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (isFast && tick && atTop) |=> status_ff[0])
        else $error("fast overflow flag missed");
    b_toggle_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        ((isFast || isPc) && modeB == COM_TOG) |=> $stable(waveB_ff) && !pinB_ff.enable)
        else $error("channel b reserved code acted");
    reset_wave_a: assert property (@(posedge core_clk)
        sys_rst |=> !waveA_ff && !waveB_ff)
        else $error("wave registers not cleared");
    pin_dir_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (!pinCtl_ff[0] || modeA == COM_OFF) |=> !pinA_ff.enable)
        else $error("pin a driven while not allowed");
    ctc_clear_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (wmode == WM_CTC && tick && matchA && modeA == COM_CLR) |=> !waveA_ff)
        else $error("clear on match failed");
    ctrl_rsv_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        ctrlA_ff[3:2] == 2'h0)
        else $error("reserved control bits set");
    pc_up_clr_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (isPc && tick && matchA && modeA == COM_CLR && !down_ff && cmpA_ff != topVal)
        |=> !waveA_ff)
        else $error("up match did not clear");

    // Steps of a full-scale phase correct turn: a rising tick at TOP, then the fall below it.
    // The variable-TOP mode is left out because its TOP reloads on the same tick.
    sequence pcTurnSeq;
        wmode == WM_PC_FF && tick && atTop && !down_ff && !(wrLane && wadr == ADDR_COUNT);
    endsequence
    sequence pcFallSeq;
        down_ff && count_ff == CNT_MAX - 8'h01;
    endsequence
    pc_turn_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        pcTurnSeq |=> pcFallSeq)
        else $error("phase correct counter did not fall after top");

    // Steps of a fast wrap on channel A with an ordinary compare value.
    sequence fastWrapASeq;
        isFast && tick && wrapFast && !matchA && cmpA_ff != topVal;
    endsequence
    fast_set_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (fastWrapASeq ##0 modeA == COM_CLR) |=> waveA_ff)
        else $error("non-inverting output not set at bottom");
    fast_clr_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (fastWrapASeq ##0 modeA == COM_SET) |=> !waveA_ff)
        else $error("inverting output not cleared at bottom");

    // Compare at TOP in fast mode: the match is ignored and the output stays at its bottom level.
    fast_max_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (isFast && tick && wrapFast && modeA == COM_CLR && cmpA_ff == topVal) |=> waveA_ff)
        else $error("fast output not constant with compare at top");

    // Compare at TOP in phase correct mode: the action happens at the turn.
    pc_max_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (isPc && tick && turnTop && modeA == COM_CLR && cmpA_ff == topVal) |=> waveA_ff)
        else $error("phase correct output not high with compare at top");

    // Compare at BOTTOM in phase correct mode must never raise a non-inverting output.
    pc_bottom_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (isPc && tick && matchA && modeA == COM_CLR && cmpA_ff == CNT_BOTTOM
         && cmpA_ff != topVal) |=> !waveA_ff)
        else $error("phase correct output rose with compare at bottom");

    // Channel B down-count match in inverting phase correct mode clears the output.
    pc_down_b_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (isPc && tick && matchB && modeB == COM_SET && down_ff && cmpB_ff != topVal
         && cmpB_ff != CNT_BOTTOM) |=> !waveB_ff)
        else $error("down match did not clear channel b");

    // Channel B match in fast non-inverting mode clears the output.
    fast_match_b_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (isFast && tick && matchB && modeB == COM_CLR && cmpB_ff != topVal) |=> !waveB_ff)
        else $error("fast match did not clear channel b");

    // Without a tick the counter and both waves hold, apart from a software write to the counter.
    tick_gate_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (!tick && !(wrLane && wadr == ADDR_COUNT))
        |=> $stable(count_ff) && $stable(waveA_ff) && $stable(waveB_ff))
        else $error("timer state moved without a tick");

    // Toggle code on A without the mode msb leaves the pin to the port.
    a_no_toggle_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        ((isFast || isPc) && !wmMsb && modeA == COM_TOG) |=> $stable(waveA_ff) && !pinA_ff.enable)
        else $error("channel a toggled without the mode msb");

    // Fast mode keeps the compare double buffered until the wrap.
    buf_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (isFast && !(tick && wrapFast)) |=> $stable(cmpA_ff))
        else $error("compare a loaded away from bottom");
    buf_load_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (isFast && tick && wrapFast) |=> cmpA_ff == $past(cmpBufA_ff))
        else $error("compare a not loaded at bottom");

    // Reserved wave modes hold the counter, since no tick is made for them.
    rsv_stop_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (isRsv && !(wrLane && wadr == ADDR_COUNT)) |=> $stable(count_ff))
        else $error("counter ran in a reserved mode");

    // The acknowledge is a single-cycle pulse.
    ack_pulse_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        wb_ack_o |=> !wb_ack_o)
        else $error("bus acknowledge held too long");
endmodule // t8pwm_wave_unit

// File: core/t8pwm_pkg.sv
// Package of constants and types for the 8-bit timer waveform unit.
package t8pwm_pkg;
    // Register byte addresses (all multiples of four).
    localparam logic [7:0] ADDR_CTRL_A = 8'h24;
    localparam logic [7:0] ADDR_CTRL_B = 8'h28;
    localparam logic [7:0] ADDR_CMP_A = 8'h2C;
    localparam logic [7:0] ADDR_CMP_B = 8'h30;
    localparam logic [7:0] ADDR_COUNT = 8'h34;
    localparam logic [7:0] ADDR_STATUS = 8'h38;
    localparam logic [7:0] ADDR_PINCTL = 8'h3C;
    // Field positions.
    localparam int MODE_A_POS = 6;
    localparam int MODE_B_POS = 4;
    localparam int WAVE_MSB_POS = 3;
    localparam int PRESC_POS = 0;
    localparam logic [7:0] CTRL_A_MASK = 8'hF3;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] CNT_BOTTOM = 8'h00;
    localparam logic [7:0] CNT_MAX = 8'hFF;
    localparam logic [9:0] PRESC_8 = 10'h007;
    localparam logic [9:0] PRESC_64 = 10'h03F;
    localparam logic [9:0] PRESC_256 = 10'h0FF;
    localparam logic [9:0] PRESC_1024 = 10'h3FF;
    // Compare output mode codes.
    localparam logic [1:0] COM_OFF = 2'h0;
    localparam logic [1:0] COM_TOG = 2'h1;
    localparam logic [1:0] COM_CLR = 2'h2;
    localparam logic [1:0] COM_SET = 2'h3;
    // Wave modes.
    typedef enum logic [2:0] {
        WM_NORMAL = 3'b000,
        WM_PC_FF = 3'b001,
        WM_CTC = 3'b010,
        WM_FAST_FF = 3'b011,
        WM_RSV4 = 3'b100,
        WM_PC_OCA = 3'b101,
        WM_RSV6 = 3'b110,
        WM_FAST_OCA = 3'b111
    } t8pwm_wmode_t;
    // Pin override group for one channel.
    typedef struct packed {
        logic level;
        logic enable;
    } t8pwm_pin_t;
endpackage : t8pwm_pkg

// File: verif/t8pwm_wave_unit_tb.sv
// Self-checking testbench for the 8-bit timer waveform unit.
module t8pwm_wave_unit_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import t8pwm_pkg::*;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [31:0] wbAdr = 32'h0;
    logic [31:0] wbDat = 32'h0;
    logic [3:0] wbSel = 4'hF;
    logic wbWe = 1'b0;
    logic wbCyc = 1'b0;
    logic wbStb = 1'b0;
    logic [31:0] wbDatO;
    logic wbAck;
    t8pwm_pin_t pinA;
    t8pwm_pin_t pinB;
    logic ovfIrq;
    int nErrors = 0;
    int totalChecks = 0;
    logic [32:0] expQ[$];
    logic [32:0] note;
    logic [7:0] r;
    // Pin enable table: control A, control B, direction, expected {B,A} enables.
    logic [7:0] enCa[6] = '{8'h03, 8'h53, 8'hA3, 8'hA3, 8'hA3, 8'h57};
    logic [7:0] enCb[6] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h09};
    logic [7:0] enDir[6] = '{8'h03, 8'h03, 8'h00, 8'h02, 8'h01, 8'h03};
    logic [1:0] enExp[6] = '{2'h0, 2'h0, 2'h0, 2'h2, 2'h1, 2'h1};

    t8pwm_wave_unit dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .wb_adr_i(wbAdr),
        .wb_dat_i(wbDat), .wb_dat_o(wbDatO), .wb_sel_i(wbSel), .wb_we_i(wbWe),
        .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_ack_o(wbAck), .pinA(pinA), .pinB(pinB),
        .ovfIrq(ovfIrq));

    // Free-running 100 MHz clock.
    always #5 core_clk = ~core_clk;

    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] s);
        totalChecks++;
        if (s !== e) begin
            nErrors++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic finishTest();
        $display("checks %0d mismatches %0d", totalChecks, nErrors);
        if (nErrors == 0 && totalChecks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Pairs every acknowledge with the oldest note; only reads carry a value to compare.
    always @(posedge core_clk) begin
        if (wbAck === 1'b1) begin
            if (expQ.size() == 0) begin
                check("unrequested ack", 32'h0, 32'h1);
            end else begin
                note = expQ.pop_front();
                if (note[32]) check("read data", note[31:0], wbDatO);
            end
        end
    end

    // One classic cycle; the request stands until ack is sampled high.
    task automatic wbXfer(input logic we, input logic [7:0] a, input logic [7:0] d,
                          input logic [7:0] e);
        int n;
        n = 0;
        expQ.push_back({~we, 24'h0, e});
        @(posedge core_clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= {24'h0, a};
        wbDat <= {24'h0, d};
        do begin
            @(posedge core_clk);
            n++;
        end while (wbAck !== 1'b1 && n < 20);
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
        if (n >= 20) check("bus ack", 32'h1, 32'h0);
    endtask

    // Stops the counter and loads compares in normal mode, where loads are immediate.
    task automatic setup(input logic [7:0] ca, cb, ma, mb, dir);
        wbXfer(1'b1, ADDR_CTRL_B, 8'h00, 8'h00);
        wbXfer(1'b1, ADDR_CTRL_A, 8'h00, 8'h00);
        wbXfer(1'b1, ADDR_COUNT, 8'h00, 8'h00);
        wbXfer(1'b1, ADDR_CMP_A, ma, 8'h00);
        wbXfer(1'b1, ADDR_CMP_B, mb, 8'h00);
        wbXfer(1'b1, ADDR_PINCTL, dir, 8'h00);
        wbXfer(1'b1, ADDR_CTRL_A, ca, 8'h00);
        wbXfer(1'b1, ADDR_STATUS, 8'h07, 8'h00);
        wbXfer(1'b1, ADDR_CTRL_B, cb, 8'h00);
    endtask

    function automatic logic lvl(input bit chB);
        return chB ? pinB.level : pinA.level;
    endfunction

    // Measures one full period from rising edge to rising edge, bounded in cycles.
    task automatic measure(input bit chB, output int hi, output int per);
        logic p, c;
        int n;
        hi = 0;
        per = 0;
        n = 0;
        p = lvl(chB);
        c = p;
        while (!(!p && c) && n < 3000) begin
            @(posedge core_clk);
            p = c;
            c = lvl(chB);
            n++;
        end
        do begin
            if (c) hi++;
            @(posedge core_clk);
            p = c;
            c = lvl(chB);
            per++;
            n++;
        end while (!(!p && c) && n < 6000);
    endtask

    // The first period after a mode change is discarded.
    task automatic pwmCase(input logic [7:0] ca, cb, ma, mb, input bit chB, input int eHi, ePer);
        int hi, per;
        setup(ca, cb, ma, mb, 8'h03);
        measure(chB, hi, per);
        measure(chB, hi, per);
        check("period", ePer, per);
        check("high time", eHi, hi);
        $display("test waveform ctrl %h cmp %h %h done", ca, ma, mb);
    endtask

    task automatic steady(input logic [7:0] ca, ma, input logic e);
        int bad;
        bad = 0;
        setup(ca, 8'h01, ma, 8'h00, 8'h03);
        repeat (600) @(posedge core_clk);
        repeat (520) begin
            @(posedge core_clk);
            if (pinA.level !== e) bad++;
        end
        check("off-level cycles", 32'h0, bad);
        $display("test steady ctrl %h cmp %h done", ca, ma);
    endtask

    // Main sequence: reset, registers, waveforms, pin override, overflow flag.
    initial begin
        r = 8'($urandom(75));
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        check("reset outputs", 32'h0, {27'h0, pinA, pinB, ovfIrq});
        wbXfer(1'b0, ADDR_CTRL_A, 8'h00, 8'h00);
        wbXfer(1'b1, ADDR_CTRL_A, r, 8'h00);
        wbXfer(1'b0, ADDR_CTRL_A, 8'h00, r & 8'hF3);
        wbXfer(1'b1, 8'h40, 8'hFF, 8'h00);
        wbXfer(1'b0, 8'h40, 8'h00, 8'h00);
        wbSel <= 4'hE;
        wbXfer(1'b1, ADDR_CTRL_A, ~r, 8'h00);
        wbSel <= 4'hF;
        wbXfer(1'b0, ADDR_CTRL_A, 8'h00, r & 8'hF3);
        $display("test registers done");
        pwmCase(8'h83, 8'h01, 8'h40, 8'h00, 1'b0, 65, 256);
        pwmCase(8'hC3, 8'h01, 8'h40, 8'h00, 1'b0, 191, 256);
        pwmCase(8'h23, 8'h01, 8'h00, 8'h80, 1'b1, 129, 256);
        pwmCase(8'h83, 8'h02, 8'h40, 8'h00, 1'b0, 520, 2048);
        r = 8'($urandom_range(254, 1));
        pwmCase(8'h83, 8'h01, r, 8'h00, 1'b0, r + 1, 256);
        pwmCase(8'h81, 8'h01, 8'h40, 8'h00, 1'b0, 128, 510);
        pwmCase(8'hC1, 8'h01, 8'h40, 8'h00, 1'b0, 382, 510);
        pwmCase(8'h43, 8'h09, 8'h00, 8'h00, 1'b0, 1, 2);
        pwmCase(8'h40, 8'h01, 8'h10, 8'h00, 1'b0, 256, 512);
        pwmCase(8'h42, 8'h01, 8'h10, 8'h00, 1'b0, 17, 34);
        steady(8'h81, 8'h00, 1'b0);
        steady(8'h81, 8'hFF, 1'b1);
        steady(8'hC1, 8'hFF, 1'b0);
        steady(8'h83, 8'hFF, 1'b1);
        steady(8'h80, 8'h10, 1'b0);
        steady(8'hC0, 8'h10, 1'b1);
        for (int i = 0; i < 6; i++) begin
            setup(enCa[i], enCb[i], 8'h40, 8'h40, enDir[i]);
            repeat (3) @(posedge core_clk);
            check("pin enables", {30'h0, enExp[i]}, {30'h0, pinB.enable, pinA.enable});
        end
        $display("test pin override done");
        foreach (enCb[i]) if (i < 2) begin
            setup(i == 0 ? 8'h83 : 8'h81, 8'h01, 8'h40, 8'h40, 8'h03);
            repeat (600) @(posedge core_clk);
            check("overflow set", 32'h1, {31'h0, ovfIrq});
            wbXfer(1'b1, ADDR_CTRL_B, 8'h00, 8'h00);
            wbXfer(1'b1, ADDR_STATUS, 8'h01, 8'h00);
            repeat (2) @(posedge core_clk);
            check("overflow cleared", 32'h0, {31'h0, ovfIrq});
            wbXfer(1'b0, ADDR_STATUS, 8'h00, 8'h06);
        end
        $display("test overflow done");
        finishTest();
    end

    // Cuts a hung run short after a bounded number of cycles.
    initial begin
        repeat (80000) @(posedge core_clk);
        check("run length", 32'h0, 32'h1);
        finishTest();
    end
endmodule // t8pwm_wave_unit_tb
